// ### design/i2cmt_map.svh
// Constants for the two-pin bus transaction engine: timing, pin layout, reset values
`ifndef I2CMT_MAP_SVH
`define I2CMT_MAP_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define I2CMT_CLK_KHZ     100000
`define I2CMT_RATE_KBPS   81
// Four quarter steps per bus bit; rounded down so the rate is never below target
`define I2CMT_QTR_CYC     (`I2CMT_CLK_KHZ / (`I2CMT_RATE_KBPS * 4))
// ------------------------------------------------------------
// Pin layout and byte fields
// ------------------------------------------------------------
`define I2CMT_PAIR_LOW    4'h0
`define I2CMT_PAIR_HIGH   4'h8
`define I2CMT_SDA_POS     4'h0
`define I2CMT_SCL_POS     4'h1
`define I2CMT_DIR_POS     0
`define I2CMT_DIR_WRITE   1'b0
`define I2CMT_DIR_READ    1'b1
`define I2CMT_ACK_BIT     4'h8
`define I2CMT_CAP_DEPTH   16
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define I2CMT_PIN_RST     10'h000
`define I2CMT_BYTE_RST    8'h00
`endif

// ### design/i2cmt_pkg.sv
// Types shared by the bus transaction engine
`include "i2cmt_map.svh"
package i2cmt_pkg;
   // Main sequencer states
   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_START = 3'b001,
      S_BIT   = 3'b010,
      S_FETCH = 3'b011,
      S_STOP  = 3'b100
   } i2cmt_state_t;
   // Which byte of the transaction is on the wire
   typedef enum logic [2:0] {
      G_ID_W  = 3'b000,
      G_ADDRH = 3'b001,
      G_ADDRL = 3'b010,
      G_ID_R  = 3'b011,
      G_DATA  = 3'b100
   } i2cmt_stage_t;
   // Handling of received bytes
   typedef enum logic [1:0] {
      M_STRING = 2'b00,
      M_WAIT   = 2'b01,
      M_SKIP   = 2'b10
   } i2cmt_mode_t;
   // One command as latched at acceptance
   typedef struct packed {
      logic        isRead;
      logic        pinHigh;
      logic [7:0]  targetIdByte;
      logic [7:0]  addrHighByte;
      logic [7:0]  addressLowByte;
      logic        useLow;
      i2cmt_mode_t mode;
      logic [7:0]  count;
      logic [7:0]  endByte;
      logic        useEnd;
      logic        useLen;
   } i2cmt_cmd_t;
   // Whole state of the engine
   typedef struct packed {
      i2cmt_state_t                        st;
      i2cmt_stage_t                        stage;
      logic [8:0]                          qCnt;
      logic [1:0]                          q;
      logic [3:0]                          bitIdx;
      logic                                isRx;
      logic                                lastByte;
      logic                                lastTx;
      logic [7:0]                          shift;
      logic [7:0]                          count;
      logic [4:0]                          capIdx;
      logic [4:0]                          matchIdx;
      logic [`I2CMT_CAP_DEPTH-1:0][7:0]    capBuf;
      logic [`I2CMT_CAP_DEPTH-1:0][7:0]    patBuf;
      i2cmt_cmd_t                          cmd;
      logic                                sdaLow;
      logic                                sclLow;
      logic [9:0]                          pinOe;
      logic [9:0]                          pinOut;
      logic                                busy;
      logic                                done;
      logic                                matched;
      logic                                ackError;
      logic                                pinError;
      logic                                txReady;
      logic [7:0]                          rdData;
   } i2cmt_regs_t;
endpackage

// ### design/i2cmt_engine.sv
// Single-master two-wire bus transaction engine with read modes and streamed writes
// Notes on behaviour
// [R1] Pin pair selector is 0 or 8; SDA on that pin, SCL on next.
// [R2] Pins toggle between drive and input during a transfer, end as inputs.
// [R3] Bus bit rate is about 81 kbit per second.
// [R4] Every item on the bus is an 8-bit unit.
// [R5] First byte holds 7-bit target id above a direction bit, 0 write, 1 read.
// [R6] An 8-bit address byte follows the target byte.
// [R7] With low address enabled, high byte goes first, then low byte.
// [R8] Data bytes follow the last address byte; many per session; read samples target.
// [R9] Every transaction opens with Start and closes with Stop by itself.
// [R10] A ninth clock after each byte carries the receiver's acknowledge.
// [R11] The target acknowledges every byte the engine sends.
// [R12] On reads the supplied direction bit is ignored and forced.
// [R13] Read: id with 0, address bytes, id with 1, then receive data.
// [R14] Write: id with 0, address bytes, then each data byte.
// [R15] Sole master only: no arbitration and no target behaviour.
// [R16] Identifier and both address values accept 0 through 255.
// [R17] String mode stores up to L bytes, stops on end byte, zero-fills rest.
// [R18] Wait mode receives until bytes match a pattern of L or zero-ended length.
// [R19] Skip mode receives and discards a given count of bytes.
// [R20] A read uses repeated Start, not Stop, before the read id byte.
// [R21] Receiver acknowledges each data byte but leaves the last one unacknowledged.
`timescale 1ns/100ps
`include "i2cmt_map.svh"
module i2cmt_engine
   import i2cmt_pkg::*;
(
   // Clock, reset, freeze
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // Command
   input  wire logic        cmdStart,
   input  wire logic        busReadCommand,
   input  wire logic [3:0]  pinSel,
   input  wire logic [7:0]  targetIdByte,
   input  wire logic [7:0]  addrHighByte,
   input  wire logic [7:0]  addressLowByte,
   input  wire logic        useLowAddr,
   input  wire i2cmt_mode_t rxMode,
   input  wire logic [7:0]  rxCount,
   input  wire logic        useLen,
   input  wire logic [7:0]  endByte,
   input  wire logic        useEnd,
   // Outgoing data stream for writes
   input  wire logic [7:0]  txData,
   input  wire logic        txValid,
   input  wire logic        txLast,
   output logic             txReady,
   // Pattern store and capture readout
   input  wire logic        patWe,
   input  wire logic [3:0]  patIdx,
   input  wire logic [7:0]  patData,
   input  wire logic [3:0]  rdIdx,
   output logic [7:0]       rdData,
   // Status
   output logic             busy,
   output logic             done,
   output logic             matched,
   output logic             ackError,
   output logic             pinError,
   // General-purpose pins, open drain
   input  wire logic [9:0]  gpioIn,
   output logic [9:0]       gpioOut,
   output logic [9:0]       gpioOe
);
   localparam logic [8:0] QTR_LAST = 9'(`I2CMT_QTR_CYC - 1);

   i2cmt_regs_t r;
   i2cmt_regs_t n;
   logic        tick;
   logic        sdaIn;
   logic [7:0]  rxByte;
   logic [4:0]  patLen;
   logic [`I2CMT_CAP_DEPTH-1:0] patZero;

   // ------------------------------------------------------------
   // Pin pair, quarter-bit timer, pattern length
   // ------------------------------------------------------------
   assign sdaIn  = r.cmd.pinHigh ? gpioIn[`I2CMT_PAIR_HIGH + `I2CMT_SDA_POS]
                                 : gpioIn[`I2CMT_PAIR_LOW + `I2CMT_SDA_POS]; // R1
   assign tick   = (r.qCnt == QTR_LAST); // R3
   assign rxByte = {r.shift[6:0], sdaIn};

   // Zero flag per stored pattern entry
   genvar gi;
   generate
      for (gi = 0; gi < `I2CMT_CAP_DEPTH; gi++) begin : g_zero
         assign patZero[gi] = (r.patBuf[gi] == `I2CMT_BYTE_RST);
      end
   endgenerate

   // Pattern length is the count if given, else the first zero entry
   always_comb begin
      patLen = 5'(`I2CMT_CAP_DEPTH);
      for (int i = `I2CMT_CAP_DEPTH - 1; i >= 0; i--) begin
         if (patZero[i]) begin
            patLen = 5'(i);
         end
      end
      if (r.cmd.useLen) begin
         patLen = (r.cmd.count > 8'(`I2CMT_CAP_DEPTH)) ? 5'(`I2CMT_CAP_DEPTH)
                                                       : r.cmd.count[4:0]; // R18
      end
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      logic       last;
      logic [4:0] nextMatch;
      last      = 1'b0;
      nextMatch = 5'h00;
      n         = r;
      n.done    = 1'b0;
      n.txReady = 1'b0;
      n.pinOut  = `I2CMT_PIN_RST;
      n.rdData  = r.capBuf[rdIdx];
      n.qCnt    = (r.st == S_IDLE || r.st == S_FETCH || tick) ? 9'h000 : r.qCnt + 9'h001;
      if (r.st != S_IDLE && r.st != S_FETCH && tick) begin
         n.q = r.q + 2'h1;
      end
      // Pattern entries may only change between transactions
      if (patWe && r.st == S_IDLE) begin
         n.patBuf[patIdx] = patData;
      end
      case (r.st)
         S_IDLE: begin
            if (cmdStart) begin
               if (pinSel == `I2CMT_PAIR_LOW || pinSel == `I2CMT_PAIR_HIGH) begin // R1
                  n.cmd      = '{busReadCommand, pinSel == `I2CMT_PAIR_HIGH, targetIdByte,
                                 addrHighByte, addressLowByte, useLowAddr, rxMode,
                                 rxCount, endByte, useEnd, useLen}; // R16
                  n.st       = S_START; // R9
                  n.stage    = G_ID_W;
                  n.q        = 2'h0;
                  n.busy     = 1'b1;
                  n.ackError = 1'b0;
                  n.pinError = 1'b0;
                  n.matched  = 1'b0;
                  n.count    = `I2CMT_BYTE_RST;
                  n.capIdx   = 5'h00;
                  n.matchIdx = 5'h00;
                  n.capBuf   = '0; // R17
               end else begin
                  n.pinError = 1'b1;
               end
            end
         end
         // Start or repeated start: SDA falls while SCL is released
         S_START: begin
            if (tick) begin
               case (r.q)
                  2'h0: n.sdaLow = 1'b0;
                  2'h1: n.sclLow = 1'b0;
                  2'h2: n.sdaLow = 1'b1; // R9
                  default: begin
                     n.sclLow = 1'b1;
                     n.st     = S_BIT;
                     n.bitIdx = 4'h0;
                     n.isRx   = 1'b0;
                     n.shift  = {r.cmd.targetIdByte[7:1],
                                 (r.stage == G_ID_R) ? `I2CMT_DIR_READ
                                                     : `I2CMT_DIR_WRITE}; // R5 R12 R13 R14
                  end
               endcase
            end
         end
         // One bit per four quarters; bit index 8 is the acknowledge slot
         S_BIT: begin
            if (tick) begin
               case (r.q)
                  2'h0: begin
                     if (r.bitIdx == `I2CMT_ACK_BIT) begin
                        n.sdaLow = r.isRx && !r.lastByte; // R10 R21
                     end else begin
                        n.sdaLow = !r.isRx && !r.shift[7]; // R4
                     end
                  end
                  2'h1: n.sclLow = 1'b0;
                  2'h2: begin
                     if (r.bitIdx == `I2CMT_ACK_BIT) begin
                        if (!r.isRx && sdaIn) begin
                           n.ackError = 1'b1; // R11
                        end
                     end else if (r.isRx) begin
                        n.shift = rxByte; // R8
                        if (r.bitIdx == 4'h7) begin
                           n.count = r.count + 8'h01;
                           case (r.cmd.mode)
                              M_STRING: begin
                                 last = (r.count + 8'h01 == r.cmd.count) ||
                                        (r.cmd.useEnd && rxByte == r.cmd.endByte); // R17
                                 if (!(r.cmd.useEnd && rxByte == r.cmd.endByte) &&
                                     r.capIdx < 5'(`I2CMT_CAP_DEPTH)) begin
                                    n.capBuf[r.capIdx[3:0]] = rxByte;
                                    n.capIdx = r.capIdx + 5'h01;
                                 end
                              end
                              M_WAIT: begin
                                 if (r.matchIdx < 5'(`I2CMT_CAP_DEPTH) &&
                                     rxByte == r.patBuf[r.matchIdx[3:0]]) begin
                                    nextMatch = r.matchIdx + 5'h01;
                                 end else if (rxByte == r.patBuf[0]) begin
                                    nextMatch = 5'h01;
                                 end
                                 n.matchIdx = nextMatch;
                                 last       = (nextMatch >= patLen); // R18
                                 n.matched  = last;
                              end
                              default: begin
                                 last = (r.count + 8'h01 == r.cmd.count); // R19
                              end
                           endcase
                           n.lastByte = last;
                        end
                     end
                  end
                  default: begin
                     n.sclLow = 1'b1;
                     n.shift  = r.isRx ? r.shift : {r.shift[6:0], 1'b0};
                     n.bitIdx = r.bitIdx + 4'h1;
                     if (r.bitIdx == `I2CMT_ACK_BIT) begin
                        n.bitIdx = 4'h0;
                        n.isRx   = 1'b0;
                        if (r.ackError || (r.isRx && r.lastByte)) begin
                           n.st = S_STOP;
                        end else begin
                           case (r.stage)
                              G_ID_W: begin
                                 n.stage = G_ADDRH;
                                 n.shift = r.cmd.addrHighByte; // R6
                              end
                              G_ADDRH, G_ADDRL: begin
                                 if (r.stage == G_ADDRH && r.cmd.useLow) begin
                                    n.stage = G_ADDRL;
                                    n.shift = r.cmd.addressLowByte; // R7
                                 end else if (r.cmd.isRead) begin
                                    n.stage = G_ID_R;
                                    n.st    = S_START; // R20
                                 end else begin
                                    n.stage = G_DATA;
                                    n.st    = S_FETCH; // R14
                                 end
                              end
                              G_ID_R: begin
                                 n.stage    = G_DATA;
                                 n.isRx     = 1'b1; // R13
                                 n.lastByte = 1'b0;
                              end
                              default: begin
                                 if (r.isRx) begin
                                    n.isRx = 1'b1;
                                 end else begin
                                    n.st = r.lastTx ? S_STOP : S_FETCH;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
         end
         // SCL is held low while the data source stalls
         S_FETCH: begin
            if (txValid) begin
               n.shift     = txData;
               n.lastTx    = txLast;
               n.txReady   = 1'b1;
               n.st        = S_BIT;
               n.q         = 2'h0;
            end
         end
         // Stop: SDA rises while SCL is released, then both pins are inputs
         default: begin
            if (tick) begin
               case (r.q)
                  2'h0: n.sdaLow = 1'b1;
                  2'h1: n.sclLow = 1'b0;
                  2'h2: n.sdaLow = 1'b0; // R9
                  default: begin
                     n.st   = S_IDLE;
                     n.busy = 1'b0;
                     n.done = 1'b1;
                  end
               endcase
            end
         end
      endcase
      // Open drain: only the selected pair is ever pulled low
      n.pinOe = `I2CMT_PIN_RST; // R2 R15
      n.pinOe[(n.cmd.pinHigh ? `I2CMT_PAIR_HIGH : `I2CMT_PAIR_LOW) + `I2CMT_SDA_POS] = n.sdaLow;
      n.pinOe[(n.cmd.pinHigh ? `I2CMT_PAIR_HIGH : `I2CMT_PAIR_LOW) + `I2CMT_SCL_POS] = n.sclLow;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         r <= '0;
      end else if (clkEn) begin
         r <= n;
      end
   end

   assign txReady  = r.txReady;
   assign rdData   = r.rdData;
   assign busy     = r.busy;
   assign done     = r.done;
   assign matched  = r.matched;
   assign ackError = r.ackError;
   assign pinError = r.pinError;
   assign gpioOut  = r.pinOut;
   assign gpioOe   = r.pinOe;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence stopEnd;
      r.st == S_STOP && r.q == 2'h3 && tick && clkEn;
   endsequence
   sequence addrDoneRead;
      r.st == S_BIT && r.q == 2'h3 && tick && clkEn && r.bitIdx == `I2CMT_ACK_BIT &&
      !r.ackError && r.cmd.isRead && (r.stage == G_ADDRL ||
      (r.stage == G_ADDRH && !r.cmd.useLow));
   endsequence

   a_idle_pins_free: assert property (r.st == S_IDLE |-> gpioOe == `I2CMT_PIN_RST) // R2
      else $error("pins driven while idle");
   a_pair_only: assert property ((gpioOe & (r.cmd.pinHigh ? 10'h0FF : 10'h3FC)) == 10'h000) // R1
      else $error("pin outside selected pair driven");
   a_quarter_bound: assert property (r.qCnt <= QTR_LAST) // R3
      else $error("quarter timer overran");
   a_start_opens: assert property (r.st == S_IDLE && cmdStart && clkEn &&
      (pinSel == `I2CMT_PAIR_LOW || pinSel == `I2CMT_PAIR_HIGH) |=> r.st == S_START && busy) // R9
      else $error("accepted command did not open with start");
   a_stop_closes: assert property (stopEnd |=> r.st == S_IDLE && done ##1 !done) // R9
      else $error("stop did not finish with one done pulse");
   a_restart_read: assert property (addrDoneRead |=> r.st == S_START && r.stage == G_ID_R) // R20
      else $error("read did not use repeated start");
   a_read_dir_one: assert property (r.st == S_START && r.stage == G_ID_R && r.q == 2'h3 &&
      tick && clkEn |=> r.shift[`I2CMT_DIR_POS] == `I2CMT_DIR_READ) // R12
      else $error("read id byte not forced to read");
   a_nack_last: assert property (r.st == S_BIT && r.isRx && r.bitIdx == `I2CMT_ACK_BIT &&
      r.q == 2'h1 |-> r.sdaLow == !r.lastByte) // R21
      else $error("receive acknowledge level wrong");
   a_capture_bound: assert property (r.capIdx <= 5'(`I2CMT_CAP_DEPTH)) // R17
      else $error("capture index beyond array");
endmodule

// ### verification/i2cmt_target_model.sv
// Behavioural two-wire target: logs bytes sent to it, acknowledges, returns ptr^A5 on reads
`timescale 1ns/100ps
module i2cmt_target_model (
   // Bus levels and fault control
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [5:0] nackAt,
   // Open-drain pull on the data line
   output logic            sdaPull
);
   logic [7:0] sh, ptr, d;
   logic [7:0] rxLog [0:31];
   logic       rd, goRd, first, quit;
   int         bitN, rxN, starts, stops;
   realtime    t1, period;
   initial begin
      sdaPull = 1'b0;
      {rd, goRd, first, quit} = 4'h0;
      {bitN, rxN, starts, stops} = '0;
      {sh, ptr, d} = '0;
   end
   // Start or repeated start restarts byte framing
   always @(negedge sda) if (scl === 1'b1) begin
      starts++;
      {bitN, rd, quit, sdaPull} = '0;
      first = 1'b1;
   end
   always @(posedge sda) if (scl === 1'b1) stops++;
   // Sample on rising clock; a high ninth bit of a read byte is the master giving up
   always @(posedge scl) begin
      if (bitN < 8 && !rd) sh = {sh[6:0], sda};
      if (bitN == 8 && rd) quit = sda;
      if (bitN == 1) t1 = $realtime;
      if (bitN == 2) period = $realtime - t1;
      bitN++;
   end
   // Data only moves while the clock is low, so no false start or stop is made here
   always @(negedge scl) begin
      if (bitN == 8 && !rd) begin
         rxLog[rxN] = sh;
         sdaPull = (rxN != nackAt);
         goRd = first && sh[0];
         if (!first) ptr = sh;
         first = 1'b0;
         rxN++;
      end else begin
         if (bitN == 9) begin
            bitN = 0;
            if (rd && !quit) ptr++;
            if (goRd) rd = 1'b1;
            goRd = 1'b0;
         end
         d = ptr ^ 8'hA5;
         sdaPull = rd && !quit && bitN < 8 && !d[7 - bitN];
      end
   end
endmodule

// ### verification/i2cmt_engine_tb.sv
// Self-checking bench for the two-wire transaction engine
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin nChecks++; if ((got) !== (ex)) begin failures++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module i2cmt_engine_tb
   import i2cmt_pkg::*;
;
   logic        mclk, reset, cmdStart, busReadCommand, useLowAddr, useEnd;
   logic [3:0]  pinSel, rdIdx, cur;
   logic [7:0]  targetIdByte, addrHighByte, addressLowByte, rxCount, endByte, txData;
   logic        txValid, txLast, txReady, busy, done, matched, ackError, pinError, pull;
   logic [7:0]  rdData;
   logic [9:0]  gpioOe, gpioOut, pins;
   logic [5:0]  nackAt;
   i2cmt_mode_t rxMode;
   int          failures, nChecks, b, s0, p0;
   // Pull-ups on every pin; either party may pull low
   always_comb begin
      pins = ~gpioOe;
      if (pull) pins[cur] = 1'b0;
   end
   i2cmt_engine dut (.mclk(mclk), .reset(reset), .clkEn(1'b1), .cmdStart(cmdStart),
      .busReadCommand(busReadCommand), .pinSel(pinSel), .targetIdByte(targetIdByte),
      .addrHighByte(addrHighByte), .addressLowByte(addressLowByte),
      .useLowAddr(useLowAddr), .rxMode(rxMode), .rxCount(rxCount), .useLen(1'b0),
      .endByte(endByte), .useEnd(useEnd), .txData(txData), .txValid(txValid),
      .txLast(txLast), .txReady(txReady), .patWe(1'b0), .patIdx(4'h0), .patData(8'h00),
      .rdIdx(rdIdx), .rdData(rdData), .busy(busy), .done(done), .matched(matched),
      .ackError(ackError), .pinError(pinError), .gpioIn(pins), .gpioOut(gpioOut),
      .gpioOe(gpioOe));
   i2cmt_target_model tgt (.scl(pins[cur + 4'h1]), .sda(pins[cur]), .nackAt(nackAt),
      .sdaPull(pull));
   always #5 mclk = ~mclk;
   // -------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------
   task automatic results;
      if (failures == 0 && nChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic issue(input logic r, input logic [3:0] p, input logic [7:0] i, a, l,
                        input logic u);
      b = tgt.rxN;
      s0 = tgt.starts;
      p0 = tgt.stops;
      @(posedge mclk);
      #1;
      {busReadCommand, pinSel, targetIdByte, addrHighByte} = {r, p, i, a};
      {addressLowByte, useLowAddr, cmdStart} = {l, u, 1'b1};
      if (p == 4'h0 || p == 4'h8) cur = p;
      @(posedge mclk);
      #1;
      cmdStart = 1'b0;
   endtask
   // Bounded wait; a missing completion shows up as a mismatch on done
   task automatic waitDone;
      repeat (80000) begin
         @(posedge mclk);
         #1;
         if (done === 1'b1) break;
      end
      `CHK("done", 1'b1, done)
   endtask
   task automatic cap(input logic [3:0] i, input logic [7:0] ex);
      rdIdx = i;
      @(posedge mclk);
      #1;
      `CHK("rdData", ex, rdData)
   endtask
   // -------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------
   task automatic t_read;
      {rxMode, rxCount, useEnd, endByte} = {M_STRING, 8'h04, 1'b1, 8'hB4};
      issue(1'b1, 4'h0, 8'hA1, 8'h10, 8'h00, 1'b0);
      `CHK("busy", 1'b1, busy)
      waitDone();
      `CHK("idW", 8'hA0, tgt.rxLog[b])
      `CHK("addr", 8'h10, tgt.rxLog[b + 1])
      `CHK("idR", 8'hA1, tgt.rxLog[b + 2])
      `CHK("sent", 3, tgt.rxN - b)
      `CHK("starts", 2, tgt.starts - s0)
      `CHK("stops", 1, tgt.stops - p0)
      cap(4'h0, 8'hB5);
      for (int k = 1; k < 4; k++) cap(k[3:0], 8'h00);
      `CHK("gpioOe", 10'h000, gpioOe)
      `CHK("busy", 1'b0, busy)
   endtask
   // Write on the upper pair, two address bytes, one streamed data byte
   task automatic t_write;
      issue(1'b0, 4'h8, 8'h57, 8'h12, 8'h34, 1'b1);
      {txData, txValid, txLast} = {8'h9C, 1'b1, 1'b1};
      repeat (60000) begin
         @(posedge mclk);
         #1;
         if (txReady === 1'b1) break;
      end
      `CHK("txReady", 1'b1, txReady)
      txValid = 1'b0;
      waitDone();
      `CHK("idW", 8'h56, tgt.rxLog[b])
      `CHK("addrH", 8'h12, tgt.rxLog[b + 1])
      `CHK("addrL", 8'h34, tgt.rxLog[b + 2])
      `CHK("data", 8'h9C, tgt.rxLog[b + 3])
      `CHK("bitTime", 12320, int'(tgt.period))
      `CHK("ackError", 1'b0, ackError)
      `CHK("stops", 1, tgt.stops - p0)
      `CHK("gpioOe", 10'h000, gpioOe)
      `CHK("gpioOut", 10'h000, gpioOut)
   endtask
   task automatic t_badpin;
      issue(1'b0, 4'h4, 8'hA0, 8'h00, 8'h00, 1'b0);
      repeat (3) @(posedge mclk);
      #1;
      `CHK("pinError", 1'b1, pinError)
      `CHK("busy", 1'b0, busy)
      `CHK("gpioOe", 10'h000, gpioOe)
   endtask
   // Target refuses the first byte: engine must stop at once and flag it
   task automatic t_nack;
      nackAt = tgt.rxN[5:0];
      issue(1'b1, 4'h0, 8'hA1, 8'h20, 8'h00, 1'b0);
      `CHK("pinError", 1'b0, pinError)
      waitDone();
      nackAt = 6'h3F;
      `CHK("ackError", 1'b1, ackError)
      `CHK("sent", 1, tgt.rxN - b)
      `CHK("stops", 1, tgt.stops - p0)
      `CHK("gpioOe", 10'h000, gpioOe)
   endtask
   // Watchdog sized for about 120k cycles of traffic
   initial begin
      #1300000;
      failures++;
      results();
   end
   initial begin
      {mclk, reset, cmdStart, busReadCommand, useLowAddr, useEnd, txValid, txLast} = 8'h40;
      {pinSel, rdIdx, cur, targetIdByte, addrHighByte, addressLowByte} = '0;
      {rxCount, endByte, txData, nackAt, rxMode} = {24'h000000, 6'h3F, M_STRING};
      {failures, nChecks} = '0;
      repeat (6) @(posedge mclk);
      #1;
      reset = 1'b0;
      `CHK("gpioOe", 10'h000, gpioOe)
      t_read();
      t_write();
      t_badpin();
      t_nack();
      results();
   end
endmodule
